// ---- cns_host_model.sv ----
// host controller model issuing one register request at a time
`timescale 1ns/1ps
`default_nettype none
module cns_host_model (
  // clock
  input  wire logic        clk,
  // request
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [3:0]  reg_sec,
  output var  logic [3:0]  reg_page,
  output var  logic [11:0] reg_addr,
  output var  logic [1:0]  reg_dlen,
  output var  logic [63:0] reg_wdata,
  // answer
  input  wire logic        ack,
  input  wire logic [63:0] rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sec = 4'h0;
    reg_page = 4'h0;
    reg_addr = 12'h000;
    reg_dlen = 2'h0;
    reg_wdata = 64'h0;
  end
  task automatic xfer(input logic rd, input logic [7:0] sp,
    input logic [11:0] a, input logic [1:0] dl, input logic [63:0] wd,
    output logic [63:0] rv, output logic ok);
    @(posedge clk);
    reg_rd <= rd;
    reg_wr <= !rd;
    reg_sec <= sp[7:4];
    reg_page <= sp[3:0];
    reg_addr <= a;
    reg_dlen <= dl;
    reg_wdata <= wd;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    // released address and write data lines flip so stale data is never mistaken for valid
    reg_addr <= ~a;
    reg_wdata <= ~wd;
    #1;
    ok = ack;
    rv = rdata;
  endtask
endmodule
`default_nettype wire

// ---- cns_map.vh ----
// register map and timing constants of the configuration store access block
`ifndef CNS_MAP_VH
`define CNS_MAP_VH
// shadow register offsets (16-bit locations, step of two per 32-bit word)
`define CNS_INITIAL_SPEED_DETECT_CFG 12'h080
`define CNS_REVERSE_DRIVE_BRAKE_CFG  12'h082
`define CNS_STARTUP_METHOD_CFG       12'h084
`define CNS_STARTUP_RAMP_CFG         12'h086
`define CNS_LOOP_ACCEL_PWM_CFG       12'h088
`define CNS_WINDING_STOP_CFG         12'h08A
`define CNS_BEMF_CURRENT_LOOP_CFG    12'h08C
`define CNS_SPEED_LOOP_CFG           12'h08E
`define CNS_PROTECTION_LIMIT_CFG     12'h090
`define CNS_PROTECTION_ACTION_CFG    12'h092
`define CNS_SPEED_CURVE_CFG_A        12'h094
`define CNS_SPEED_CURVE_CFG_F        12'h09E
`define CNS_ALGO_MISC_CFG_A          12'h0A0
`define CNS_ALGO_MISC_CFG_B          12'h0A2
`define CNS_PIN_FUNCTION_CFG         12'h0A4
`define CNS_DEVICE_SETUP_CFG_A       12'h0A6
`define CNS_DEVICE_SETUP_CFG_B       12'h0A8
`define CNS_PERIPHERAL_SETUP_CFG     12'h0AA
`define CNS_GATE_DRIVER_CFG_A        12'h0AC
`define CNS_GATE_DRIVER_CFG_B        12'h0AE
`define CNS_NVM_COMMAND              12'h0EA
`define CNS_ADDR_STEP                12'h002
// command words
`define CNS_CMD_PROGRAM              32'h8A500000
`define CNS_CMD_LOAD                 32'h40000000
// data length field codes
`define CNS_DLEN_16                  2'h0
`define CNS_DLEN_32                  2'h1
`define CNS_DLEN_64                  2'h2
// section and page that reach the store and working memory
`define CNS_SEC_MAIN                 4'h0
`define CNS_PAGE_MAIN                4'h0
// store geometry
`define CNS_NVM_ROWS                 16
`define CNS_ROW_BITS                 64
`define CNS_WORD_BITS                32
`define CNS_LAST_USED_ROW            4'hB
// reset values
`define CNS_SHADOW_RESET             32'h00000000
`define CNS_ERASED_ROW               64'h0000000000000000
// timing
`define CNS_CLK_KHZ                  40000
`define CNS_PROG_WAIT_MS             300
`define CNS_LOAD_WAIT_MS             100
// wait counts in clock cycles: 300 ms and 100 ms at 40 MHz
`define CNS_PROG_WAIT_CYC            24'hB71B00
`define CNS_LOAD_WAIT_CYC            24'h3D0900
`define CNS_MACRO_OP_CYC             8'h04
// macro operation codes
`define CNS_OP_READ                  2'h0
`define CNS_OP_PROGRAM               2'h1
`define CNS_OP_ERASE                 2'h2
`endif

// ---- cns_nvm_array.v ----
// non-volatile store macro: 16 rows of 64 bits, row erase, word program/read
`timescale 1ns/1ps
`default_nettype none
`include "cns_map.vh"
module cns_nvm_array #(
  parameter [7:0] OP_CYC = `CNS_MACRO_OP_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  // operation request
  input  wire        op_start,
  input  wire [1:0]  op_code,
  input  wire [3:0]  op_row,
  input  wire        op_half,
  input  wire [31:0] op_wdata,
  // result
  output reg  [31:0] op_rdata,
  output reg         op_done
);
  // **************************************************************
  // storage and operation timer
  // **************************************************************
  reg [63:0] mem [0:`CNS_NVM_ROWS-1];
  reg [7:0]  cnt;
  reg        active;
  reg [1:0]  code;
  reg [3:0]  row;
  reg        half;
  reg [31:0] wdata;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt      <= 8'h00;
      active   <= 1'b0;
      code     <= `CNS_OP_READ;
      row      <= 4'h0;
      half     <= 1'b0;
      wdata    <= 32'h00000000;
      op_rdata <= 32'h00000000;
      op_done  <= 1'b0;
    end else if (ce) begin
      op_done <= 1'b0;
      if (!active && op_start) begin
        active <= 1'b1;
        cnt    <= OP_CYC;
        code   <= op_code;
        row    <= op_row;
        half   <= op_half;
        wdata  <= op_wdata;
      end else if (active) begin
        if (cnt > 8'h01) begin
          cnt <= cnt - 8'h01;
        end else begin
          active  <= 1'b0;
          op_done <= 1'b1;
          if (code == `CNS_OP_READ) begin
            op_rdata <= half ? mem[row][63:32] : mem[row][31:0];
          end
        end
      end
    end
  end

  // array content carries no reset: it is what survives power loss
  always @(posedge clk) begin
    if (ce && active && cnt <= 8'h01) begin
      if (code == `CNS_OP_ERASE) begin
        mem[row] <= `CNS_ERASED_ROW;
      end else if (code == `CNS_OP_PROGRAM) begin
        if (half) begin
          mem[row][63:32] <= wdata;
        end else begin
          mem[row][31:0] <= wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- cns_store_access.v ----
// configuration store access: shadow registers, command register, sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cns_map.vh"
module cns_store_access #(
  parameter [23:0] PROG_WAIT_CYC = `CNS_PROG_WAIT_CYC,
  parameter [23:0] LOAD_WAIT_CYC = `CNS_LOAD_WAIT_CYC,
  parameter [7:0]  MACRO_OP_CYC  = `CNS_MACRO_OP_CYC
) (
  // clock, reset, enable
  input  wire        CLOCK,
  input  wire        RSTN,
  input  wire        CE,
  // register request from the serial layer
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [3:0]  REG_SEC,
  input  wire [3:0]  REG_PAGE,
  input  wire [11:0] REG_ADDR,
  input  wire [1:0]  REG_DLEN,
  input  wire [63:0] REG_WDATA,
  // register answer
  output reg         REG_ACK,
  output reg  [63:0] REG_RDATA,
  // motor state
  input  wire        MOTOR_SPINNING,
  // store status
  output reg         NVM_BUSY,
  output reg         NVM_CMD_REFUSED
);
  // **************************************************************
  // states
  // **************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ISSUE = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h3;

  reg  [31:0] shadow [0:23];
  reg  [2:0]  state;
  reg  [1:0]  op;
  reg  [3:0]  row;
  reg         half;
  reg         prog_seq;
  reg         boot_pend;
  reg  [23:0] budget;
  wire [31:0] nvm_rdata;
  wire        nvm_done;
  wire        op_start;
  wire [4:0]  seq_idx;
  integer     i;

  assign seq_idx  = {row, half};
  assign op_start = (state == ST_ISSUE) && !MOTOR_SPINNING;

  // **************************************************************
  // address decode
  // **************************************************************
  reg        sel_ok;
  reg [11:0] addr_b;
  reg        hit_a;
  reg        hit_b;
  reg [4:0]  idx_a;
  reg [4:0]  idx_b;
  reg        wr_a;
  reg        wr_b;
  reg        half_only;
  reg        cmd_seen;
  reg [31:0] cmd_word;
  reg        cmd_prog;
  reg        cmd_load;
  reg [11:0] off_a;
  reg [11:0] off_b;

  always @* begin
    sel_ok = (REG_SEC == `CNS_SEC_MAIN) && (REG_PAGE == `CNS_PAGE_MAIN)
             && !REG_ADDR[0];
    addr_b = REG_ADDR + `CNS_ADDR_STEP;
    off_a  = REG_ADDR - `CNS_INITIAL_SPEED_DETECT_CFG;
    off_b  = addr_b - `CNS_INITIAL_SPEED_DETECT_CFG;
    idx_a  = off_a[5:1];
    idx_b  = off_b[5:1];
    hit_a  = sel_ok && (REG_ADDR >= `CNS_INITIAL_SPEED_DETECT_CFG)
             && (REG_ADDR <= `CNS_GATE_DRIVER_CFG_B);
    hit_b  = sel_ok && (addr_b >= `CNS_INITIAL_SPEED_DETECT_CFG)
             && (addr_b <= `CNS_GATE_DRIVER_CFG_B);
    half_only = (REG_DLEN == `CNS_DLEN_16);
    // shadows are frozen while a store operation uses them
    wr_a = REG_WR && hit_a && !NVM_BUSY && (REG_DLEN != 2'h3);
    wr_b = REG_WR && hit_b && !NVM_BUSY && (REG_DLEN == `CNS_DLEN_64);
    cmd_seen = 1'b0;
    cmd_word = 32'h00000000;
    if (REG_WR && sel_ok && REG_ADDR == `CNS_NVM_COMMAND
        && (REG_DLEN == `CNS_DLEN_32 || REG_DLEN == `CNS_DLEN_64)) begin
      cmd_seen = 1'b1;
      cmd_word = REG_WDATA[31:0];
    end else if (REG_WR && sel_ok && REG_DLEN == `CNS_DLEN_64
                 && addr_b == `CNS_NVM_COMMAND) begin
      cmd_seen = 1'b1;
      cmd_word = REG_WDATA[63:32];
    end
    cmd_prog = cmd_seen && (cmd_word == `CNS_CMD_PROGRAM);
    cmd_load = cmd_seen && (cmd_word == `CNS_CMD_LOAD);
  end

  // unmapped and write-only locations read back as zero
  function [31:0] read_word;
    input        hit;
    input [4:0]  idx;
    begin
      read_word = hit ? shadow[idx] : 32'h00000000;
    end
  endfunction

  // **************************************************************
  // read data shaping
  // **************************************************************
  reg [31:0] word_a;
  reg [31:0] word_b;
  reg [31:0] rd_lo;
  reg [31:0] rd_hi;

  // a 16-bit read returns only the low half of the addressed word
  always @* begin
    word_a = read_word(hit_a, idx_a);
    word_b = read_word(hit_b, idx_b);
    rd_lo  = half_only ? (word_a & 32'h0000FFFF) : word_a;
    rd_hi  = 32'h00000000;
    if (REG_DLEN == `CNS_DLEN_64) begin
      rd_hi = word_b;
    end
  end

  // **************************************************************
  // register answer
  // **************************************************************
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      REG_ACK   <= 1'b0;
      REG_RDATA <= 64'h0000000000000000;
    end else if (CE) begin
      REG_ACK <= REG_WR || REG_RD;
      if (REG_RD) begin
        REG_RDATA <= {rd_hi, rd_lo};
      end
    end
  end

  // **************************************************************
  // shadow registers
  // **************************************************************
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (i = 0; i < 24; i = i + 1) begin
        shadow[i] <= `CNS_SHADOW_RESET;
      end
    end else if (CE) begin
      if (wr_a) begin
        if (half_only) begin
          shadow[idx_a][15:0] <= REG_WDATA[15:0];
        end else begin
          shadow[idx_a] <= REG_WDATA[31:0];
        end
      end
      if (wr_b) begin
        shadow[idx_b] <= REG_WDATA[63:32];
      end
      if (nvm_done && !prog_seq) begin
        shadow[seq_idx] <= nvm_rdata;
      end
    end
  end

  // **************************************************************
  // store sequencer
  // **************************************************************
  wire        last_word;
  wire [3:0]  next_row;
  wire [1:0]  next_op;

  // twelve rows carry the 24 shadows; rows above them stay untouched
  assign last_word = half && (row == `CNS_LAST_USED_ROW);
  assign next_row  = row + 4'h1;
  assign next_op   = prog_seq ? `CNS_OP_ERASE : `CNS_OP_READ;

  // the store is only erased here, each row just before it is programmed in a program
  // sequence, so the register port itself has no erase path
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state           <= ST_IDLE;
      op              <= `CNS_OP_READ;
      row             <= 4'h0;
      half            <= 1'b0;
      prog_seq        <= 1'b0;
      boot_pend       <= 1'b1;
      budget          <= 24'h000000;
      NVM_BUSY        <= 1'b1;
    end else if (CE) begin
      if (budget != 24'h000000) begin
        budget <= budget - 24'h000001;
      end
      case (state)
        ST_IDLE: begin
          if (boot_pend) begin
            // shadows come up holding the stored configuration
            boot_pend <= 1'b0;
            prog_seq  <= 1'b0;
            op        <= `CNS_OP_READ;
            row       <= 4'h0;
            half      <= 1'b0;
            budget    <= LOAD_WAIT_CYC;
            state     <= ST_ISSUE;
          end else if (cmd_prog && !MOTOR_SPINNING) begin
            NVM_BUSY <= 1'b1;
            prog_seq <= 1'b1;
            op       <= `CNS_OP_ERASE;
            row      <= 4'h0;
            half     <= 1'b0;
            budget   <= PROG_WAIT_CYC;
            state    <= ST_ISSUE;
          end else if (cmd_load && !MOTOR_SPINNING) begin
            NVM_BUSY <= 1'b1;
            prog_seq <= 1'b0;
            op       <= `CNS_OP_READ;
            row      <= 4'h0;
            half     <= 1'b0;
            budget   <= LOAD_WAIT_CYC;
            state    <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // a spinning motor stalls the sequence between macro steps
          if (op_start) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (nvm_done) begin
            if (op == `CNS_OP_ERASE) begin
              op    <= `CNS_OP_PROGRAM;
              half  <= 1'b0;
              state <= ST_ISSUE;
            end else if (!half) begin
              half  <= 1'b1;
              state <= ST_ISSUE;
            end else if (last_word) begin
              state <= ST_HOLD;
            end else begin
              row   <= next_row;
              half  <= 1'b0;
              op    <= next_op;
              state <= ST_ISSUE;
            end
          end
        end
        ST_HOLD: begin
          // busy spans the full wait so the host sees completion on time
          if (budget == 24'h000000) begin
            NVM_BUSY <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // **************************************************************
  // command refusal
  // **************************************************************
  // refused while spinning or while any sequence runs, the boot load
  // included, so a command is never dropped without a trace
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      NVM_CMD_REFUSED <= 1'b0;
    end else if (CE) begin
      NVM_CMD_REFUSED <= (cmd_prog || cmd_load) && (MOTOR_SPINNING
                         || state != ST_IDLE || boot_pend);
    end
  end

  // **************************************************************
  // store macro
  // **************************************************************
  cns_nvm_array #(
    .OP_CYC   (MACRO_OP_CYC)
  ) u_array (
    .clk      (CLOCK),
    .rstn     (RSTN),
    .ce       (CE),
    .op_start (op_start),
    .op_code  (op),
    .op_row   (row),
    .op_half  (half),
    .op_wdata (shadow[seq_idx]),
    .op_rdata (nvm_rdata),
    .op_done  (nvm_done)
  );
endmodule
`default_nettype wire

// ---- cns_store_access_monitor.sv ----
// concurrent checks on the configuration store access ports
`timescale 1ns/1ps
`default_nettype none
`include "cns_map.vh"
module cns_store_access_monitor #(
  parameter [23:0] PROG_WAIT_CYC = `CNS_PROG_WAIT_CYC,
  parameter [23:0] LOAD_WAIT_CYC = `CNS_LOAD_WAIT_CYC
) (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RSTN,
  input wire logic        CE,
  // register request
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [3:0]  REG_SEC,
  input wire logic [3:0]  REG_PAGE,
  input wire logic [11:0] REG_ADDR,
  input wire logic [1:0]  REG_DLEN,
  input wire logic [63:0] REG_WDATA,
  // answer and status
  input wire logic        REG_ACK,
  input wire logic [63:0] REG_RDATA,
  input wire logic        MOTOR_SPINNING,
  input wire logic        NVM_BUSY,
  input wire logic        NVM_CMD_REFUSED
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  wire       req = CE && (REG_WR || REG_RD);
  wire       cmd = CE && REG_WR && REG_SEC == 4'h0 && REG_PAGE == 4'h0
    && REG_ADDR == `CNS_NVM_COMMAND && REG_DLEN == `CNS_DLEN_32;
  wire       prog = cmd && REG_WDATA[31:0] == `CNS_CMD_PROGRAM;
  wire       load = cmd && REG_WDATA[31:0] == `CNS_CMD_LOAD;
  reg [23:0] busy_cnt;
  // ****************
  // busy length
  // ****************
  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      busy_cnt <= 24'h000000;
    else if (!NVM_BUSY)
      busy_cnt <= 24'h000000;
    else
      busy_cnt <= busy_cnt + 24'h000001;
  end
  AST_ACK_AFTER_REQ: assert property (req |=> REG_ACK)
    else $error("request without acknowledge");
  AST_NO_STRAY_ACK: assert property (!req |=> !REG_ACK)
    else $error("acknowledge without request");
  AST_RDATA_HOLD: assert property (!REG_ACK |-> $stable(REG_RDATA))
    else $error("read data moved without acknowledge");
  AST_PROG_START: assert property (prog && !NVM_BUSY && !MOTOR_SPINNING
    |=> NVM_BUSY && !NVM_CMD_REFUSED)
    else $error("program command not started");
  AST_LOAD_START: assert property (load && !NVM_BUSY && !MOTOR_SPINNING
    |=> NVM_BUSY && !NVM_CMD_REFUSED)
    else $error("load command not started");
  AST_REFUSE_SPIN: assert property ((prog || load) && !NVM_BUSY
    && MOTOR_SPINNING |=> NVM_CMD_REFUSED && !NVM_BUSY)
    else $error("command accepted while spinning");
  AST_REFUSE_BUSY: assert property ((prog || load) && NVM_BUSY
    |=> NVM_CMD_REFUSED)
    else $error("command while busy not refused");
  AST_BAD_WORD: assert property (cmd && !prog && !load && !NVM_BUSY
    |=> !NVM_BUSY && !NVM_CMD_REFUSED)
    else $error("wrong command word acted on");
  AST_BUSY_MIN: assert property ($fell(NVM_BUSY)
    |-> busy_cnt >= LOAD_WAIT_CYC - 24'd2)
    else $error("store wait ended early");
  AST_BUSY_MAX: assert property (NVM_BUSY
    |-> busy_cnt <= PROG_WAIT_CYC + 24'd16)
    else $error("store wait overran");
  cover property (prog && !NVM_BUSY ##1 NVM_BUSY);
  cover property (NVM_CMD_REFUSED);
  cover property ($fell(NVM_BUSY));
endmodule
bind cns_store_access cns_store_access_monitor #(
  .PROG_WAIT_CYC(PROG_WAIT_CYC),
  .LOAD_WAIT_CYC(LOAD_WAIT_CYC)
) i_cns_store_access_monitor (
  .CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_SEC(REG_SEC), .REG_PAGE(REG_PAGE), .REG_ADDR(REG_ADDR),
  .REG_DLEN(REG_DLEN), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK),
  .REG_RDATA(REG_RDATA), .MOTOR_SPINNING(MOTOR_SPINNING),
  .NVM_BUSY(NVM_BUSY), .NVM_CMD_REFUSED(NVM_CMD_REFUSED)
);
`default_nettype wire

// ---- tb_cns_store_access.sv ----
// self-checking testbench of the configuration store access block
`timescale 1ns/1ps
`default_nettype none
`include "cns_map.vh"
module tb_cns_store_access;
  localparam [23:0] PROG_CYC = 24'd400;
  localparam [23:0] LOAD_CYC = 24'd200;
  localparam [11:0] BASE = `CNS_INITIAL_SPEED_DETECT_CFG;
  localparam [11:0] CMD = `CNS_NVM_COMMAND;
  localparam [1:0]  D32 = `CNS_DLEN_32;
  localparam [1:0]  D64 = `CNS_DLEN_64;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        spin = 1'b0;
  wire         wr, rd_q, ack, busy, refused;
  wire [3:0]   sec, page;
  wire [11:0]  addr;
  wire [1:0]   dlen;
  wire [63:0]  wdata, rdata;
  logic [63:0] rv;
  logic        ok;
  int          n;
  int          mismatches = 0;
  int          total_checks = 0;
  always #12.5 clock = ~clock;
  cns_store_access #(.PROG_WAIT_CYC(PROG_CYC), .LOAD_WAIT_CYC(LOAD_CYC),
    .MACRO_OP_CYC(8'h04)) i_cns_store_access (.CLOCK(clock), .RSTN(rstn),
    .CE(ce), .REG_WR(wr), .REG_RD(rd_q), .REG_SEC(sec), .REG_PAGE(page),
    .REG_ADDR(addr), .REG_DLEN(dlen), .REG_WDATA(wdata), .REG_ACK(ack),
    .REG_RDATA(rdata), .MOTOR_SPINNING(spin), .NVM_BUSY(busy),
    .NVM_CMD_REFUSED(refused));
  cns_host_model i_cns_host_model (.clk(clock), .reg_wr(wr), .reg_rd(rd_q),
    .reg_sec(sec), .reg_page(page), .reg_addr(addr), .reg_dlen(dlen),
    .reg_wdata(wdata), .ack(ack), .rdata(rdata));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] pat(input int k);
    pat = 32'h5A5A0000 + 32'(k) * 32'h00010003;
  endfunction
  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      mismatches++;
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic acc(input logic r, input logic [7:0] sp,
    input logic [11:0] a, input logic [1:0] dl, input logic [63:0] wd);
    i_cns_host_model.xfer(r, sp, a, dl, wd, rv, ok);
    check("ack", {63'h0, ok}, 64'h1);
  endtask
  task automatic wr32(input logic [11:0] a, input logic [1:0] dl,
    input logic [63:0] wd);
    acc(1'b0, 8'h00, a, dl, wd);
  endtask
  task automatic rd32(input logic [11:0] a, input logic [1:0] dl,
    input logic [63:0] exp);
    acc(1'b1, 8'h00, a, dl, 64'h0);
    check("read data", rv, exp);
  endtask
  task automatic flags(input logic b, input logic r);
    check("busy", {63'h0, busy}, {63'h0, b});
    check("refused", {63'h0, refused}, {63'h0, r});
  endtask
  task automatic wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 2000) begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic fill(input logic [31:0] x);
    for (int i = 0; i < 12; i++)
      wr32(BASE + 12'(4 * i), D64, {pat(2 * i + 1) ^ x, pat(2 * i) ^ x});
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    wait_idle;
    fill(32'h00000000);
    for (int k = 0; k < 24; k++)
      rd32(BASE + 12'(2 * k), D32, {32'h0, pat(k)});
    rd32(BASE, D64, {pat(1), pat(0)});
    rd32(BASE + 12'h002, `CNS_DLEN_16, {32'h0, pat(1) & 32'h0000FFFF});
    rd32(12'h0B0, D32, 64'h0);
    rd32(CMD, D32, 64'h0);
    acc(1'b0, 8'h10, BASE, D32, 64'h0);
    acc(1'b0, 8'h01, BASE, D32, 64'h0);
    acc(1'b1, 8'h10, BASE, D32, 64'h0);
    check("reserved read", rv, 64'h0);
    rd32(BASE, D32, {32'h0, pat(0)});
    wr32(CMD, D32, 64'h000000008A500001);
    flags(1'b0, 1'b0);
    wr32(CMD, `CNS_DLEN_16, {32'h0, `CNS_CMD_LOAD});
    flags(1'b0, 1'b0);
    @(posedge clock);
    spin <= 1'b1;
    wr32(CMD, D32, {32'h0, `CNS_CMD_PROGRAM});
    flags(1'b0, 1'b1);
    @(posedge clock);
    spin <= 1'b0;
    wr32(CMD, D32, {32'h0, `CNS_CMD_PROGRAM});
    flags(1'b1, 1'b0);
    wr32(CMD, D32, {32'h0, `CNS_CMD_LOAD});
    flags(1'b1, 1'b1);
    wr32(BASE, D32, 64'h0);
    wait_idle;
    check("program wait", {63'h0, n >= PROG_CYC - 3}, 64'h1);
    rd32(BASE, D32, {32'h0, pat(0)});
    fill(32'hFFFFFFFF);
    rd32(BASE, D32, {32'h0, ~pat(0)});
    @(posedge clock);
    ce <= 1'b0;
    i_cns_host_model.xfer(1'b0, 8'h00, BASE, D32, 64'h0, rv, ok);
    check("frozen ack", {63'h0, ok}, 64'h0);
    @(posedge clock);
    ce <= 1'b1;
    rd32(BASE, D32, {32'h0, ~pat(0)});
    wr32(CMD, D32, {32'h0, `CNS_CMD_LOAD});
    flags(1'b1, 1'b0);
    wait_idle;
    check("load wait", {63'h0, n >= LOAD_CYC - 3}, 64'h1);
    for (int k = 0; k < 24; k++)
      rd32(BASE + 12'(2 * k), D32, {32'h0, pat(k)});
    wr32(BASE, `CNS_DLEN_16, 64'h000000000000C3C3);
    rd32(BASE, D32, {32'h0, (pat(0) & 32'hFFFF0000) | 32'h0000C3C3});
    wr32(CMD - 12'h002, D64, {`CNS_CMD_LOAD, 32'h00000000});
    flags(1'b1, 1'b0);
    wait_idle;
    rd32(BASE, D32, {32'h0, pat(0)});
    give_verdict;
  end
endmodule
`default_nettype wire
